// [logic/ta_smbus_target.v]
// two-wire bus target: byte protocols and alert response
`timescale 1ns/1ns
`include "ta_defines.vh"
module ta_smbus_target #(
  parameter [6:0] OWN_ADDR = `TA_OWN_ADDR_DEF
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // bus pins
  input wire scl_in,
  input wire sda_in,
  output reg sda_out_r,
  output reg sda_oe_r,
  // register side
  input wire alert_pend,
  input wire [7:0] rd_data,
  output reg [7:0] cmd_r,
  output reg wr_stb_r,
  output reg [7:0] wr_data_r,
  output reg ara_done_r
);
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_ADDR = 3'd1;
  localparam [2:0] S_AACK = 3'd2;
  localparam [2:0] S_ACK = 3'd3;
  localparam [2:0] S_RX = 3'd4;
  localparam [2:0] S_DACK = 3'd5;
  localparam [2:0] S_TX = 3'd6;
  localparam [2:0] S_TXEND = 3'd7;

  reg scl_s1, scl_s2, scl_s3;
  reg sda_s1, sda_s2, sda_s3;
  reg [2:0] state_r;
  reg [2:0] cnt_r;
  reg [7:0] sh_r;
  reg rd_r;
  reg ara_r;
  reg first_r;
  reg rack_r;

  wire scl_rise = scl_s2 & ~scl_s3;
  wire scl_fall = ~scl_s2 & scl_s3;
  wire start_ev = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
  wire stop_ev = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;
  wire [7:0] rx_byte = {sh_r[6:0], sda_s2};
  wire [7:0] tx_byte = ara_r ? {OWN_ADDR, 1'b1} : rd_data;

  always @(posedge sys_clk) begin
    scl_s1 <= scl_in;
    scl_s2 <= scl_s1;
    scl_s3 <= scl_s2;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
    sda_s3 <= sda_s2;
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
      cnt_r <= 3'd0;
      sh_r <= 8'h00;
      rd_r <= 1'b0;
      ara_r <= 1'b0;
      first_r <= 1'b0;
      rack_r <= 1'b0;
      sda_out_r <= 1'b0;
      sda_oe_r <= 1'b0;
      cmd_r <= `TA_CMD_RST;
      wr_stb_r <= 1'b0;
      wr_data_r <= 8'h00;
      ara_done_r <= 1'b0;
    end else begin
      wr_stb_r <= 1'b0;
      ara_done_r <= 1'b0;
      if (start_ev) begin
        state_r <= S_ADDR;
        cnt_r <= 3'd0;
        sda_oe_r <= 1'b0;
        rack_r <= 1'b0;
      end else if (stop_ev) begin
        state_r <= S_IDLE;
        sda_oe_r <= 1'b0;
      end else begin
        case (state_r)
          S_IDLE: begin
            sda_oe_r <= 1'b0;
          end
          S_ADDR: if (scl_rise) begin
            sh_r <= rx_byte;
            cnt_r <= cnt_r + 3'd1;
            if (cnt_r == 3'd7) begin
              state_r <= S_AACK;
            end
          end
          S_AACK: if (scl_fall) begin
            if (sh_r[7:1] == OWN_ADDR) begin
              sda_oe_r <= 1'b1;
              rd_r <= sh_r[0];
              ara_r <= 1'b0;
              first_r <= 1'b1;
              state_r <= S_ACK;
            end else if (sh_r[7:1] == `TA_ARA_ADDR && sh_r[0] &&
                         alert_pend) begin
              // answer the alert response only while alerting
              sda_oe_r <= 1'b1;
              rd_r <= 1'b1;
              ara_r <= 1'b1;
              state_r <= S_ACK;
            end else begin
              state_r <= S_IDLE;
            end
          end
          S_ACK: if (scl_fall) begin
            cnt_r <= 3'd0;
            if (rd_r) begin
              // msb first, open drain pulls low for a zero
              sda_oe_r <= ~tx_byte[7];
              sh_r <= {tx_byte[6:0], 1'b0};
              state_r <= S_TX;
            end else begin
              sda_oe_r <= 1'b0;
              state_r <= S_RX;
            end
          end
          S_RX: if (scl_rise) begin
            sh_r <= rx_byte;
            cnt_r <= cnt_r + 3'd1;
            if (cnt_r == 3'd7) begin
              state_r <= S_DACK;
              if (first_r) begin
                // command byte selects the register
                cmd_r <= rx_byte;
                first_r <= 1'b0;
              end else begin
                wr_stb_r <= 1'b1;
                wr_data_r <= rx_byte;
              end
            end
          end
          S_DACK: if (scl_fall) begin
            sda_oe_r <= 1'b1;
            state_r <= S_ACK;
          end
          S_TX: begin
            if (scl_rise) begin
              if (!sda_oe_r && !sda_s2) begin
                // lost arbitration to a lower address
                state_r <= S_IDLE;
              end else begin
                cnt_r <= cnt_r + 3'd1;
                if (cnt_r == 3'd7) begin
                  state_r <= S_TXEND;
                end
              end
            end else if (scl_fall) begin
              sda_oe_r <= ~sh_r[7];
              sh_r <= {sh_r[6:0], 1'b0};
            end
          end
          S_TXEND: begin
            if (scl_fall && !rack_r) begin
              // master answers the data byte with no acknowledge
              sda_oe_r <= 1'b0;
              rack_r <= 1'b1;
            end else if (scl_rise && rack_r) begin
              // whole byte sent: alert response read succeeded
              ara_done_r <= ara_r;
              rack_r <= 1'b0;
              state_r <= S_IDLE;
            end
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end
endmodule

// [logic/ta_defines.vh]
// constants shared by the temperature alarm block
`ifndef TA_DEFINES_VH
`define TA_DEFINES_VH

// bus addresses
`define TA_ARA_ADDR 7'h0C
`define TA_OWN_ADDR_DEF 7'h18

// reset values of the byte registers
`define TA_HI_RST 8'h7F
`define TA_HI1_ALT_RST 8'h6E
`define TA_LO_RST 8'hC9
`define TA_TEMP_RST 8'h00
`define TA_CFG_RST 8'h00
`define TA_CMD_RST 8'h00

// encoded result limits, whole degrees
`define TA_TEMP_MAX 127
`define TA_TEMP_MIN -65
`define TA_TEMP_MAX_CODE 8'h7F
`define TA_TEMP_MIN_CODE 8'hBF
`define TA_TEMP_SHORT_CODE 8'h00

// command codes; per-channel codes step from these bases
`define TA_CMD_RD_TEMP0 8'h00
`define TA_CMD_RD_STAT1 8'h05
`define TA_CMD_RD_STAT2 8'h06
`define TA_CMD_RD_CFG 8'h07
`define TA_CMD_RD_HI0 8'h08
`define TA_CMD_WR_CFG 8'h12
`define TA_CMD_WR_HI0 8'h13

// configuration field
`define TA_CFG_MASK_BIT 7

`endif

// [logic/ta_alarm_top.v]
// multichannel temperature alarm: thresholds, encoding, alert latch
//
// What this block does
// - alert when a result equals or passes its high or low threshold.
// - separate high and low threshold register per channel.
// - high thresholds reset to 0111 1111, +127 degrees.
// - variant option resets remote channel one high threshold to +110.
// - low thresholds reset to 1100 1001, -55 degrees.
// - results are two's-complement bytes clamped to -65..+127.
// - diode open detector sampled into status at each conversion start.
// - no diode fault shown after reset until a conversion starts.
// - shorted remote input gives result 0000 0000.
// - remote input shorted to supply forces +127 on every channel.
// - alert stays latched until alert response read succeeds.
// - four byte protocols; receive byte uses last command byte.
// - alert response address 0001100 returns own address, low wins.
// - one degree per bit, msb first, half degree added before rounding.
`timescale 1ns/1ns
`include "ta_defines.vh"
module ta_alarm_top #(
  parameter NCH = 5,
  parameter RAW_W = 12,
  parameter FRAC = 4,
  parameter HI1_ALT = 0,
  parameter [6:0] OWN_ADDR = `TA_OWN_ADDR_DEF
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // two-wire bus pins
  input wire serial_bus_clock_pin,
  input wire serial_bus_data_pin_in,
  output wire serial_bus_data_pin_out,
  output wire serial_bus_data_pin_oe,
  // open-drain alert pin
  output reg alert_pin_out_r,
  output reg alert_pin_oe_r,
  // converter front end, same clock
  input wire conv_start,
  input wire conv_done,
  input wire [NCH*RAW_W-1:0] raw_temp,
  input wire [NCH-2:0] remote_diode_open,
  input wire [NCH-2:0] remote_diode_short,
  input wire remote_supply_short
);
  localparam [RAW_W:0] HALF = 1 << (FRAC - 1);
  localparam DW = RAW_W + 1 - FRAC;

  wire [7:0] cmd;
  wire wr_stb;
  wire [7:0] wr_data;
  wire ara_done;
  wire [7:0] rd_data;
  wire [NCH-1:0] hit;
  wire [NCH-1:0] alarm_now;
  wire [8*(NCH+1)-1:0] rd_acc;

  reg [NCH-2:0] fault_r;
  reg [NCH-1:0] alarm_r;
  reg [7:0] cfg_r;

  ta_smbus_target #(
    .OWN_ADDR(OWN_ADDR)
  ) u_target (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .scl_in(serial_bus_clock_pin),
    .sda_in(serial_bus_data_pin_in),
    .sda_out_r(serial_bus_data_pin_out),
    .sda_oe_r(serial_bus_data_pin_oe),
    .alert_pend(alert_pin_oe_r),
    .rd_data(rd_data),
    .cmd_r(cmd),
    .wr_stb_r(wr_stb),
    .wr_data_r(wr_data),
    .ara_done_r(ara_done)
  );

  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_ch
      localparam [7:0] C_TEMP = `TA_CMD_RD_TEMP0 + i;
      localparam [7:0] C_RHI = `TA_CMD_RD_HI0 + 2 * i;
      localparam [7:0] C_RLO = `TA_CMD_RD_HI0 + 2 * i + 1;
      localparam [7:0] C_WHI = `TA_CMD_WR_HI0 + 2 * i;
      localparam [7:0] C_WLO = `TA_CMD_WR_HI0 + 2 * i + 1;
      localparam [7:0] HI_RST = (i == 1 && HI1_ALT != 0) ?
                                `TA_HI1_ALT_RST : `TA_HI_RST;
      localparam signed [DW-1:0] DMAX = `TA_TEMP_MAX;
      localparam signed [DW-1:0] DMIN = `TA_TEMP_MIN;

      reg [7:0] temp_r;
      reg [7:0] hi_r;
      reg [7:0] lo_r;
      reg [7:0] code;
      wire [RAW_W-1:0] raw = raw_temp[i*RAW_W +: RAW_W];
      // half degree offset then floor to whole degrees
      wire [RAW_W:0] rnd = {raw[RAW_W-1], raw} + HALF;
      wire signed [DW-1:0] deg = rnd[RAW_W:FRAC];
      wire shorted;
      wire [7:0] rd_part;

      if (i == 0) begin : g_loc
        assign shorted = 1'b0;
      end else begin : g_rem
        assign shorted = remote_diode_short[i-1];
      end

      always @* begin
        if (remote_supply_short) begin
          code = `TA_TEMP_MAX_CODE;
        end else if (shorted) begin
          code = `TA_TEMP_SHORT_CODE;
        end else if (deg > DMAX) begin
          code = `TA_TEMP_MAX_CODE;
        end else if (deg < DMIN) begin
          code = `TA_TEMP_MIN_CODE;
        end else begin
          code = deg[7:0];
        end
      end

      // equality counts as reaching a threshold
      assign hit[i] = ($signed(code) >= $signed(hi_r)) ||
                      ($signed(code) <= $signed(lo_r));

      always @(posedge sys_clk) begin
        if (sys_rst) begin
          temp_r <= `TA_TEMP_RST;
          hi_r <= HI_RST;
          lo_r <= `TA_LO_RST;
        end else begin
          if (conv_done) begin
            temp_r <= code;
          end
          // one high and one low limit per channel
          if (wr_stb && cmd == C_WHI) begin
            hi_r <= wr_data;
          end
          if (wr_stb && cmd == C_WLO) begin
            lo_r <= wr_data;
          end
        end
      end

      assign rd_part = (cmd == C_TEMP) ? temp_r :
                       (cmd == C_RHI) ? hi_r :
                       (cmd == C_RLO) ? lo_r : 8'h00;
      assign rd_acc[8*(i+1) +: 8] = rd_acc[8*i +: 8] | rd_part;
    end
  endgenerate

  assign alarm_now = conv_done ? hit : {NCH{1'b0}};

  // status and configuration bytes; unmapped commands read zero
  assign rd_acc[7:0] =
    (cmd == `TA_CMD_RD_STAT1) ? {{(9-NCH){1'b0}}, fault_r} :
    (cmd == `TA_CMD_RD_STAT2) ? {{(8-NCH){1'b0}}, alarm_r} :
    (cmd == `TA_CMD_RD_CFG) ? cfg_r : 8'h00;
  assign rd_data = rd_acc[8*NCH +: 8];

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      fault_r <= {(NCH-1){1'b0}};
      alarm_r <= {NCH{1'b0}};
      cfg_r <= `TA_CFG_RST;
      alert_pin_out_r <= 1'b0;
      alert_pin_oe_r <= 1'b0;
    end else begin
      if (conv_start) begin
        fault_r <= remote_diode_open;
      end
      if (conv_done) begin
        alarm_r <= hit;
      end
      if (wr_stb && cmd == `TA_CMD_WR_CFG) begin
        cfg_r <= wr_data;
      end
      alert_pin_out_r <= 1'b0;
      // a new alarm wins over a clear in the same cycle
      if (!cfg_r[`TA_CFG_MASK_BIT] &&
          ((|alarm_now) || (conv_done && (|fault_r)))) begin
        alert_pin_oe_r <= 1'b1;
      end else if (ara_done) begin
        alert_pin_oe_r <= 1'b0;
      end
    end
  end
endmodule

// [bench/ta_alarm_chk.sv]
// port assertions for the temperature alarm block
`timescale 1ns/1ns
module ta_alarm_chk #(
  parameter NCH = 5,
  parameter RAW_W = 12
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // bus and alert pins
  input wire serial_bus_clock_pin,
  input wire serial_bus_data_pin_in,
  input wire serial_bus_data_pin_out,
  input wire serial_bus_data_pin_oe,
  input wire alert_pin_out_r,
  input wire alert_pin_oe_r,
  // converter side
  input wire conv_start,
  input wire conv_done,
  input wire [NCH*RAW_W-1:0] raw_temp,
  input wire [NCH-2:0] remote_diode_open,
  input wire [NCH-2:0] remote_diode_short,
  input wire remote_supply_short
);
  reg scl_q_r;
  reg [7:0] since_rise_r;
  reg [7:0] since_fall_r;
  wire scl = serial_bus_clock_pin;
  // cycles since the last bus clock edges, saturating
  always @(posedge sys_clk) begin
    scl_q_r <= scl;
    if (sys_rst | (scl & ~scl_q_r))
      since_rise_r <= sys_rst ? 8'hFF : 8'h00;
    else
      since_rise_r <= since_rise_r + {7'h00, ~&since_rise_r};
    if (sys_rst | (~scl & scl_q_r))
      since_fall_r <= sys_rst ? 8'hFF : 8'h00;
    else
      since_fall_r <= since_fall_r + {7'h00, ~&since_fall_r};
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_scl_held;
    scl [*6];
  endsequence
  sequence s_alert_drop;
    !$past(sys_rst) ##0 $fell(alert_pin_oe_r);
  endsequence
  a_data_out_low: assert property (!serial_bus_data_pin_out)
    else $error("data pin driven high");
  a_alert_out_low: assert property (!alert_pin_out_r)
    else $error("alert pin driven high");
  a_rst_alert_free: assert property (disable iff (1'b0)
    sys_rst |=> !alert_pin_oe_r) else $error("alert after reset");
  a_rst_bus_free: assert property (disable iff (1'b0)
    sys_rst |=> !serial_bus_data_pin_oe) else $error("data after reset");
  a_alert_on_conv: assert property ($rose(alert_pin_oe_r)
    |-> $past(conv_done)) else $error("alert set without conversion");
  a_alert_clear_bus: assert property (s_alert_drop
    |-> since_rise_r < 8'd16) else $error("alert cleared off bus");
  a_scl_high_oe: assert property (s_scl_held
    |-> $stable(serial_bus_data_pin_oe)) else $error("data moved, clock high");
  a_oe_near_fall: assert property (serial_bus_data_pin_oe
    |-> since_fall_r < 8'd14) else $error("data held too long");
endmodule
bind ta_alarm_top ta_alarm_chk #(.NCH(NCH), .RAW_W(RAW_W)) u_ta_alarm_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst),
  .serial_bus_clock_pin(serial_bus_clock_pin),
  .serial_bus_data_pin_in(serial_bus_data_pin_in),
  .serial_bus_data_pin_out(serial_bus_data_pin_out),
  .serial_bus_data_pin_oe(serial_bus_data_pin_oe),
  .alert_pin_out_r(alert_pin_out_r), .alert_pin_oe_r(alert_pin_oe_r),
  .conv_start(conv_start), .conv_done(conv_done), .raw_temp(raw_temp),
  .remote_diode_open(remote_diode_open),
  .remote_diode_short(remote_diode_short),
  .remote_supply_short(remote_supply_short)
);

// [bench/ta_host_model.sv]
// two-wire host master, 160 ns bit time
`timescale 1ns/1ns
module ta_host_model (
  // bus wires
  output reg scl,
  output wire sda,
  // device pull-down
  input wire dev_oe
);
  reg sda_r;
  // open drain with pull-up
  assign sda = sda_r & ~dev_oe;
  initial begin
    scl = 1'b1;
    sda_r = 1'b1;
  end
  // start, or repeated start from clock low
  task start;
    begin
      #40 sda_r = 1'b1;
      #40 scl = 1'b1;
      #40 sda_r = 1'b0;
      #40 scl = 1'b0;
    end
  endtask
  task stop;
    begin
      #40 sda_r = 1'b0;
      #40 scl = 1'b1;
      #40 sda_r = 1'b1;
      #40;
    end
  endtask
  // eight bits msb first and the ninth; ones release the line
  task xfer(input [8:0] d, output [8:0] q);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1) begin
        #40 sda_r = d[i];
        #40 scl = 1'b1;
        #75 q[i] = sda;
        #5 scl = 1'b0;
      end
    end
  endtask
  // mode 0 write, 1 send, 2 read, 3 receive byte
  task txn(input [1:0] mode, input [6:0] a, input [7:0] c, input [7:0] d,
           output [7:0] q, output nak);
    reg [8:0] r;
    begin
      q = 8'h00;
      start;
      xfer({a, mode == 2'd3, 1'b1}, r);
      nak = r[0];
      if (mode != 2'd3) begin
        xfer({c, 1'b1}, r);
        nak = nak | r[0];
        if (mode == 2'd0) begin
          xfer({d, 1'b1}, r);
          nak = nak | r[0];
        end
        if (mode == 2'd2) begin
          start;
          xfer({a, 2'b11}, r);
          nak = nak | r[0];
        end
      end
      if (mode[1] && !nak) begin
        xfer(9'h1FF, r);
        q = r[8:1];
      end
      stop;
    end
  endtask
endmodule

// [bench/ta_alarm_tb_top.sv]
// self-checking bench for the temperature alarm block
`timescale 1ns/1ns
`include "ta_defines.vh"
`define CHK(g, e) check(g, e)
module ta_alarm_tb_top;
  reg sys_clk, sys_rst, conv_start, conv_done, sup;
  reg [59:0] raw;
  reg [3:0] dopen, dshort;
  wire scl, sda, sda_oe, alert_oe;
  integer n_mismatch, samples_checked;
  reg [7:0] q;
  reg nak;
  ta_alarm_top u_ta_alarm_top (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .serial_bus_clock_pin(scl), .serial_bus_data_pin_in(sda),
    .serial_bus_data_pin_out(), .serial_bus_data_pin_oe(sda_oe),
    .alert_pin_out_r(), .alert_pin_oe_r(alert_oe),
    .conv_start(conv_start), .conv_done(conv_done), .raw_temp(raw),
    .remote_diode_open(dopen), .remote_diode_short(dshort),
    .remote_supply_short(sup));
  ta_host_model u_ta_host_model (.scl(scl), .sda(sda), .dev_oe(sda_oe));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task check(input [7:0] g, input [7:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task rd(input [7:0] c, input [7:0] e);
    begin
      u_ta_host_model.txn(2'd2, `TA_OWN_ADDR_DEF, c, 8'h00, q, nak);
      `CHK({7'h00, nak}, 8'h00);
      `CHK(q, e);
    end
  endtask
  task conv(input [59:0] r, input [3:0] op, input [3:0] sh, input s);
    begin
      @(posedge sys_clk);
      {raw, dopen, dshort, sup} <= {r, op, sh, s};
      conv_start <= 1'b1;
      @(posedge sys_clk);
      conv_start <= 1'b0;
      conv_done <= 1'b1;
      @(posedge sys_clk);
      conv_done <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask
  task ara;
    integer k;
    begin
      u_ta_host_model.txn(2'd3, `TA_ARA_ADDR, 8'h00, 8'h00, q, nak);
      `CHK(q, {`TA_OWN_ADDR_DEF, 1'b1});
      for (k = 0; k < 50 && alert_oe !== 1'b0; k = k + 1)
        @(posedge sys_clk);
      `CHK({7'h00, alert_oe}, 8'h00);
      if (k == 50)
        print_verdict;
    end
  endtask
  task t_por;
    integer i;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        rd(8'h08 + 2 * i[7:0], 8'h7F);
        rd(8'h09 + 2 * i[7:0], 8'hC9);
      end
      rd(8'h05, 8'h00);
      $display("t_por done");
    end
  endtask
  task t_encode;
    integer i;
    reg [39:0] e;
    begin
      e = 40'hE719BF007F;
      conv(60'hE68194BA0FF87E8, 4'h1, 4'h0, 1'b0);
      for (i = 0; i < 5; i = i + 1)
        rd(i[7:0], e[8*i+:8]);
      rd(8'h05, 8'h01);
      rd(8'h06, 8'h05);
      u_ta_host_model.txn(2'd3, `TA_OWN_ADDR_DEF, 8'h00, 8'h00, q, nak);
      `CHK(q, 8'h05);
      `CHK({7'h00, alert_oe}, 8'h01);
      ara;
      u_ta_host_model.txn(2'd3, `TA_ARA_ADDR, 8'h00, 8'h00, q, nak);
      `CHK({7'h00, nak}, 8'h01);
      $display("t_encode done");
    end
  endtask
  task t_write;
    begin
      u_ta_host_model.txn(2'd0, `TA_OWN_ADDR_DEF, 8'h13, 8'h00, q, nak);
      `CHK({7'h00, nak}, 8'h00);
      rd(8'h08, 8'h00);
      rd(8'h0A, 8'h7F);
      conv(60'h0, 4'h0, 4'h0, 1'b0);
      rd(8'h06, 8'h01);
      `CHK({7'h00, alert_oe}, 8'h01);
      ara;
      $display("t_write done");
    end
  endtask
  task t_short;
    integer i;
    begin
      conv(60'h7F0000, 4'h0, 4'h1, 1'b0);
      rd(8'h01, 8'h00);
      conv(60'h0, 4'h0, 4'h0, 1'b1);
      for (i = 0; i < 5; i = i + 1)
        rd(i[7:0], 8'h7F);
      `CHK({7'h00, alert_oe}, 8'h01);
      $display("t_short done");
    end
  endtask
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    {sys_rst, conv_start, conv_done, sup} = 4'h8;
    raw = 60'h0;
    dopen = 4'hF;
    dshort = 4'h0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_por;
    t_encode;
    t_write;
    t_short;
    print_verdict;
  end
endmodule
